//--- rtl/accx_pkg.sv
// accx_pkg: constants, op codes and carrier types for the accumulator/ccr/bank datapath.
// assumes a single clock domain and apb register access.
`default_nettype none
package accx_pkg;
  // register byte offsets on apb
  localparam logic [7:0] ACCX_OFS_ACC_D    = 8'h00;
  localparam logic [7:0] ACCX_OFS_ACC_E    = 8'h04;
  localparam logic [7:0] ACCX_OFS_CCR      = 8'h08;
  localparam logic [7:0] ACCX_OFS_BANKS    = 8'h0C;
  localparam logic [7:0] ACCX_OFS_SKPC     = 8'h10;
  localparam logic [7:0] ACCX_OFS_PTRS     = 8'h14;
  localparam logic [7:0] ACCX_OFS_OP       = 8'h18;
  localparam logic [7:0] ACCX_OFS_OPND     = 8'h1C;
  localparam logic [7:0] ACCX_OFS_IRQ      = 8'h20;
  localparam logic [7:0] ACCX_OFS_BUSADR   = 8'h24;
  localparam logic [7:0] ACCX_OFS_BUSDAT   = 8'h28;
  localparam logic [7:0] ACCX_OFS_STK0     = 8'h2C;
  localparam logic [7:0] ACCX_OFS_STK1     = 8'h30;
  // ccr field positions (bank field in low nibble)
  localparam int ACCX_CCR_S  = 15;
  localparam int ACCX_CCR_N  = 11;
  localparam int ACCX_CCR_Z  = 10;
  localparam int ACCX_CCR_V  = 9;
  localparam int ACCX_CCR_C  = 8;
  localparam int ACCX_CCR_H  = 4;
  localparam int ACCX_CCR_IL = 5;
  localparam int ACCX_CCR_PB = 0;
  localparam logic [2:0]  ACCX_IRQ_TOP    = 3'h7;
  localparam logic [15:0] ACCX_CCR_RESET  = 16'h80E0;
  localparam logic [15:0] ACCX_SEG_TOP    = 16'hFFFF;
  localparam logic [19:0] ACCX_PC_RESET   = 20'h00000;
  localparam logic [19:0] ACCX_PC_STEP    = 20'h00002;
  typedef enum logic [4:0] {
    ACCX_OP_NONE  = 5'h00, ACCX_OP_INCA = 5'h01, ACCX_OP_DECA = 5'h02,
    ACCX_OP_INCB  = 5'h03, ACCX_OP_DECB = 5'h04, ACCX_OP_DAA  = 5'h05,
    ACCX_OP_ADE   = 5'h06, ACCX_OP_SDE  = 5'h07, ACCX_OP_LD32 = 5'h08,
    ACCX_OP_ST32  = 5'h09, ACCX_OP_BKLD = 5'h0A, ACCX_OP_BKRD = 5'h0B,
    ACCX_OP_CALL  = 5'h0C, ACCX_OP_RET  = 5'h0D, ACCX_OP_IRQ  = 5'h0E,
    ACCX_OP_PCINC = 5'h0F, ACCX_OP_LDE  = 5'h10, ACCX_OP_STE  = 5'h11
  } accx_op_t;
  // bank select for transfers and accesses
  typedef enum logic [2:0] {
    ACCX_BK_X = 3'h0, ACCX_BK_Y = 3'h1, ACCX_BK_Z = 3'h2,
    ACCX_BK_E = 3'h3, ACCX_BK_S = 3'h4
  } accx_bk_t;
  typedef struct packed {
    logic [3:0] index_x_bank;
    logic [3:0] index_y_bank;
    logic [3:0] index_z_bank;
    logic [3:0] data_access_bank;
  } accx_banks_t;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [19:0] addr;
    logic [31:0] data;
  } accx_bus_t;
endpackage
`default_nettype wire

//--- rtl/accx_core.sv
// accx_core: accumulators, condition codes and 20-bit address banks behind apb.
// assumes an apb master on I_CLK and a memory model on the internal bus port.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`default_nettype none
module accx_core
  import accx_pkg::*;
(
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic [31:0]      O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  input  wire logic [2:0]  I_IRQ_LEVEL,
  output accx_bus_t        O_BUS,
  output logic             O_IRQ_TAKEN
);
  logic [15:0] acc_d;
  logic [15:0] acc_e;
  logic [15:0] ccr;
  accx_banks_t banks;
  logic [3:0]  stack_bank;
  logic [15:0] pc;
  logic [15:0] idx_x;
  logic [15:0] idx_y;
  logic [15:0] idx_z;
  logic [15:0] sp;
  logic [31:0] opnd;
  logic [31:0] stk0;
  logic [31:0] stk1;
  accx_bus_t   bus;
  logic        irq_taken;
  logic [2:0]  irq_sync1;
  logic [2:0]  irq_sync2;

  wire         acc_wr  = I_PSEL && I_PENABLE && I_PWRITE;
  wire         acc_rd  = I_PSEL && !I_PENABLE && !I_PWRITE;
  wire         hit_op  = acc_wr && (I_PADDR == ACCX_OFS_OP);
  wire [4:0]   op_raw  = I_PWDATA[4:0];
  wire [2:0]   op_bk   = I_PWDATA[10:8];
  wire [7:0]   acc_a   = acc_d[15:8];
  wire [7:0]   acc_b   = acc_d[7:0];
  wire [2:0]   irq_mask = ccr[ACCX_CCR_IL+2:ACCX_CCR_IL];
  wire [3:0]   pc_bank  = ccr[ACCX_CCR_PB+3:ACCX_CCR_PB];
  wire [19:0]  pc_full  = {pc_bank, pc};
  // pc increment crosses into the bank field without software help
  wire [19:0]  pc_next_full = pc_full + ACCX_PC_STEP;
  // level 7 always passes; others must exceed the mask
  wire         irq_ok = (irq_sync2 == ACCX_IRQ_TOP) || (irq_sync2 > irq_mask);

  // indexed access e,idx: carry out of 16 bits bumps the bank for this access only
  wire [15:0]  idx_sel = (op_bk == ACCX_BK_Y) ? idx_y : (op_bk == ACCX_BK_Z) ? idx_z : idx_x;
  wire [3:0]   bk_sel  = (op_bk == ACCX_BK_Y) ? banks.index_y_bank :
                         (op_bk == ACCX_BK_Z) ? banks.index_z_bank : banks.index_x_bank;
  wire [16:0]  ofs_sum = {1'b0, idx_sel} + {1'b0, acc_e};
  wire [3:0]   eff_bk  = ofs_sum[16] ? bk_sel + 4'h1 : bk_sel;
  wire [19:0]  eff_adr = {eff_bk, ofs_sum[15:0]};
  wire [19:0]  dat_adr = {banks.data_access_bank, opnd[15:0]};
  wire [19:0]  stk_adr = {stack_bank, sp};

  // arithmetic results with conventional flags
  wire [8:0]   inca = {1'b0, acc_a} + 9'h001;
  wire [8:0]   deca = {1'b0, acc_a} - 9'h001;
  wire [8:0]   incb = {1'b0, acc_b} + 9'h001;
  wire [8:0]   decb = {1'b0, acc_b} - 9'h001;
  wire [16:0]  ade  = {1'b0, acc_e} + {1'b0, acc_d};
  wire [16:0]  sub_low_acc16_from_second  = {1'b0, acc_e} - {1'b0, acc_d};
  wire         daa_lo = ccr[ACCX_CCR_H] || (acc_a[3:0] > 4'h9);
  wire         daa_hi = ccr[ACCX_CCR_C] || (acc_a > 8'h99);
  wire [7:0]   daa_fix = {daa_hi ? 4'h6 : 4'h0, daa_lo ? 4'h6 : 4'h0};
  wire [8:0]   daa  = {1'b0, acc_a} + {1'b0, daa_fix};

  // read word latched in setup, so it stands at the zero-wait access edge
  wire [31:0]  rd_mux =
    (I_PADDR == ACCX_OFS_ACC_D)  ? {16'h0000, acc_d} :
    (I_PADDR == ACCX_OFS_ACC_E)  ? {16'h0000, acc_e} :
    (I_PADDR == ACCX_OFS_CCR)    ? {16'h0000, ccr} :
    (I_PADDR == ACCX_OFS_BANKS)  ? {16'h0000, banks} :
    (I_PADDR == ACCX_OFS_SKPC)   ? {8'h00, stack_bank, pc_full} :
    (I_PADDR == ACCX_OFS_OPND)   ? opnd :
    (I_PADDR == ACCX_OFS_IRQ)    ? {28'h0000000, irq_ok, irq_sync2} :
    (I_PADDR == ACCX_OFS_BUSADR) ? {12'h000, bus.addr} :
    (I_PADDR == ACCX_OFS_BUSDAT) ? bus.data :
    (I_PADDR == ACCX_OFS_STK0)   ? stk0 :
    (I_PADDR == ACCX_OFS_STK1)   ? stk1 : 32'h00000000;
  wire         known = (I_PADDR == ACCX_OFS_ACC_D) || (I_PADDR == ACCX_OFS_ACC_E) ||
    (I_PADDR == ACCX_OFS_CCR) || (I_PADDR == ACCX_OFS_BANKS) || (I_PADDR == ACCX_OFS_SKPC) ||
    (I_PADDR == ACCX_OFS_PTRS) || (I_PADDR == ACCX_OFS_OP) || (I_PADDR == ACCX_OFS_OPND) ||
    (I_PADDR == ACCX_OFS_IRQ) || (I_PADDR == ACCX_OFS_BUSADR) ||
    (I_PADDR == ACCX_OFS_BUSDAT) || (I_PADDR == ACCX_OFS_STK0) || (I_PADDR == ACCX_OFS_STK1);

  assign O_PREADY    = 1'b1;
  assign O_PSLVERR   = I_PSEL && I_PENABLE && !known;
  assign O_BUS       = bus;
  assign O_IRQ_TAKEN = irq_taken;

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      irq_sync1 <= 3'h0;
      irq_sync2 <= 3'h0;
      O_PRDATA  <= 32'h00000000;
    end else begin
      irq_sync1 <= I_IRQ_LEVEL;
      irq_sync2 <= irq_sync1;
      O_PRDATA  <= acc_rd ? rd_mux : O_PRDATA;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      acc_d      <= 16'h0000;
      acc_e      <= 16'h0000;
      ccr        <= ACCX_CCR_RESET;
      banks      <= '0;
      stack_bank <= 4'h0;
      pc         <= ACCX_PC_RESET[15:0];
      idx_x      <= 16'h0000;
      idx_y      <= 16'h0000;
      idx_z      <= 16'h0000;
      sp         <= 16'h0000;
      opnd       <= 32'h00000000;
      stk0       <= 32'h00000000;
      stk1       <= 32'h00000000;
      bus        <= '0;
      irq_taken  <= 1'b0;
    end else begin
      bus.valid <= 1'b0;
      irq_taken <= 1'b0;
      if (acc_wr && I_PADDR == ACCX_OFS_ACC_D) acc_d <= I_PWDATA[15:0];
      if (acc_wr && I_PADDR == ACCX_OFS_ACC_E) acc_e <= I_PWDATA[15:0];
      if (acc_wr && I_PADDR == ACCX_OFS_CCR)   ccr   <= I_PWDATA[15:0];
      if (acc_wr && I_PADDR == ACCX_OFS_OPND)  opnd  <= I_PWDATA;
      if (acc_wr && I_PADDR == ACCX_OFS_PTRS) begin
        // ptrs write: select in [17:16], value in [15:0]
        unique case (I_PWDATA[17:16])
          2'h0: idx_x <= I_PWDATA[15:0];
          2'h1: idx_y <= I_PWDATA[15:0];
          2'h2: idx_z <= I_PWDATA[15:0];
          2'h3: sp    <= I_PWDATA[15:0];
        endcase
      end
      if (hit_op) begin
        unique case (op_raw)
          ACCX_OP_INCA: begin
            acc_d[15:8] <= inca[7:0];
            ccr[ACCX_CCR_N] <= inca[7];
            ccr[ACCX_CCR_Z] <= (inca[7:0] == 8'h00);
            ccr[ACCX_CCR_V] <= (acc_a == 8'h7F);
          end
          ACCX_OP_DECA: begin
            acc_d[15:8] <= deca[7:0];
            ccr[ACCX_CCR_N] <= deca[7];
            ccr[ACCX_CCR_Z] <= (deca[7:0] == 8'h00);
            ccr[ACCX_CCR_V] <= (acc_a == 8'h80);
          end
          ACCX_OP_INCB: begin
            acc_d[7:0] <= incb[7:0];
            ccr[ACCX_CCR_N] <= incb[7];
            ccr[ACCX_CCR_Z] <= (incb[7:0] == 8'h00);
            ccr[ACCX_CCR_V] <= (acc_b == 8'h7F);
          end
          ACCX_OP_DECB: begin
            acc_d[7:0] <= decb[7:0];
            ccr[ACCX_CCR_N] <= decb[7];
            ccr[ACCX_CCR_Z] <= (decb[7:0] == 8'h00);
            ccr[ACCX_CCR_V] <= (acc_b == 8'h80);
          end
          ACCX_OP_DAA: begin
            acc_d[15:8] <= daa[7:0];
            ccr[ACCX_CCR_C] <= daa_hi || daa[8];
            ccr[ACCX_CCR_N] <= daa[7];
            ccr[ACCX_CCR_Z] <= (daa[7:0] == 8'h00);
          end
          ACCX_OP_ADE: begin
            acc_e <= ade[15:0];
            ccr[ACCX_CCR_C] <= ade[16];
            ccr[ACCX_CCR_N] <= ade[15];
            ccr[ACCX_CCR_Z] <= (ade[15:0] == 16'h0000);
            ccr[ACCX_CCR_V] <= (acc_e[15] == acc_d[15]) && (ade[15] != acc_e[15]);
          end
          ACCX_OP_SDE: begin
            acc_e <= sub_low_acc16_from_second[15:0];
            ccr[ACCX_CCR_C] <= sub_low_acc16_from_second[16];
            ccr[ACCX_CCR_N] <= sub_low_acc16_from_second[15];
            ccr[ACCX_CCR_Z] <= (sub_low_acc16_from_second[15:0] == 16'h0000);
            ccr[ACCX_CCR_V] <= (acc_e[15] != acc_d[15]) && (sub_low_acc16_from_second[15] != acc_e[15]);
          end
          ACCX_OP_LD32: begin
            acc_e <= opnd[31:16];
            acc_d <= opnd[15:0];
          end
          ACCX_OP_ST32: begin
            bus <= '{valid: 1'b1, write: 1'b1, addr: dat_adr, data: {acc_e, acc_d}};
          end
          ACCX_OP_LDE, ACCX_OP_STE: begin
            bus <= '{valid: 1'b1, write: (op_raw == ACCX_OP_STE), addr: eff_adr,
                     data: {16'h0000, acc_d}};
          end
          ACCX_OP_BKLD: begin
            unique case (op_bk)
              ACCX_BK_X: banks.index_x_bank     <= acc_b[3:0];
              ACCX_BK_Y: banks.index_y_bank     <= acc_b[3:0];
              ACCX_BK_Z: banks.index_z_bank     <= acc_b[3:0];
              ACCX_BK_E: banks.data_access_bank <= acc_b[3:0];
              ACCX_BK_S: stack_bank             <= acc_b[3:0];
              default:   stack_bank             <= stack_bank;
            endcase
          end
          ACCX_OP_BKRD: begin
            unique case (op_bk)
              ACCX_BK_X: acc_d[7:0] <= {4'h0, banks.index_x_bank};
              ACCX_BK_Y: acc_d[7:0] <= {4'h0, banks.index_y_bank};
              ACCX_BK_Z: acc_d[7:0] <= {4'h0, banks.index_z_bank};
              ACCX_BK_E: acc_d[7:0] <= {4'h0, banks.data_access_bank};
              ACCX_BK_S: acc_d[7:0] <= {4'h0, stack_bank};
              default:   acc_d[7:0] <= acc_d[7:0];
            endcase
          end
          ACCX_OP_CALL: begin
            stk0 <= {ccr, pc};
            bus  <= '{valid: 1'b1, write: 1'b1, addr: stk_adr, data: {ccr, pc}};
            sp   <= sp - 16'h0004;
            pc   <= opnd[15:0];
            ccr[ACCX_CCR_PB+3:ACCX_CCR_PB] <= opnd[19:16];
          end
          ACCX_OP_IRQ: begin
            if (irq_ok) begin
              stk1 <= {ccr, pc};
              bus  <= '{valid: 1'b1, write: 1'b1, addr: stk_adr, data: {ccr, pc}};
              sp   <= sp - 16'h0004;
              ccr[ACCX_CCR_IL+2:ACCX_CCR_IL] <= irq_sync2;
              irq_taken <= 1'b1;
            end
          end
          ACCX_OP_RET: begin
            pc <= stk0[15:0];
            ccr[ACCX_CCR_PB+3:ACCX_CCR_PB] <= stk0[ACCX_CCR_PB+19:ACCX_CCR_PB+16];
            sp <= sp + 16'h0004;
          end
          ACCX_OP_PCINC: begin
            pc <= pc_next_full[15:0];
            ccr[ACCX_CCR_PB+3:ACCX_CCR_PB] <= pc_next_full[19:16];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ret may touch only the pc bank nibble; flags and mask must survive
  property p_ret_keeps_flags;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (hit_op && op_raw == ACCX_OP_RET) |=> (ccr[15:4] == $past(ccr[15:4]));
  endproperty
  a_ret_keeps_flags: assert property (p_ret_keeps_flags) else $error("ret altered flags");

  property p_reset_mask;
    @(posedge I_CLK) !I_RST_N |=> (irq_mask == ACCX_IRQ_TOP);
  endproperty
  a_reset_mask: assert property (p_reset_mask) else $error("mask not 7 after reset");

  property p_st32_whole;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (hit_op && op_raw == ACCX_OP_ST32) |=> (bus.valid && bus.data == $past({acc_e, acc_d}));
  endproperty
  a_st32_whole: assert property (p_st32_whole) else $error("32-bit store split");

  property p_irq_gate;
    @(posedge I_CLK) disable iff (!I_RST_N)
      irq_taken |-> ($past(irq_sync2) == ACCX_IRQ_TOP || $past(irq_sync2) > $past(irq_mask));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("masked irq taken");

  sequence s_call;
    hit_op && op_raw == ACCX_OP_CALL;
  endsequence
  property p_call_stack;
    @(posedge I_CLK) disable iff (!I_RST_N) s_call |=> (stk0 == $past({ccr, pc}));
  endproperty
  a_call_stack: assert property (p_call_stack) else $error("call stack wrong");

  property p_pc_carry;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (hit_op && op_raw == ACCX_OP_PCINC) |=> (pc_full == $past(pc_full) + ACCX_PC_STEP);
  endproperty
  a_pc_carry: assert property (p_pc_carry) else $error("pc carry lost");

  property p_bank_fixed;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (hit_op && op_raw == ACCX_OP_STE) |=> $stable(banks);
  endproperty
  a_bank_fixed: assert property (p_bank_fixed) else $error("bank changed by access");

  property p_eff_bump;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (hit_op && op_raw == ACCX_OP_STE && ofs_sum[16]) |=>
        (bus.addr[19:16] == $past(bk_sel) + 4'h1);
  endproperty
  a_eff_bump: assert property (p_eff_bump) else $error("bank bump missing");

  property p_irq_stack;
    @(posedge I_CLK) disable iff (!I_RST_N) irq_taken |-> (stk1 == $past({ccr, pc}));
  endproperty
  a_irq_stack: assert property (p_irq_stack) else $error("irq stack wrong");
endmodule
`default_nettype wire

//--- rtl/accx_unused.sv
`default_nettype none
`default_nettype wire

//--- bench/accx_mem_model.sv
// accx_mem_model: memory standing on the core's internal bus.
// assumes O_BUS valid is a one-cycle pulse on the core clock.
`default_nettype none
module accx_mem_model
  import accx_pkg::*;
(
  input  wire logic      i_clk,
  input  wire accx_bus_t i_bus,
  output logic [19:0]    o_last_addr,
  output logic [31:0]    o_last_data,
  output logic           o_last_write,
  output var int         o_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [0:255];
  int          cnt = 0;
  assign o_count = cnt;
  // whole word taken in one access, no byte lanes to merge
  always @(posedge i_clk) begin
    if (i_bus.valid === 1'b1) begin
      o_last_addr <= i_bus.addr;
      o_last_data <= i_bus.data;
      o_last_write <= i_bus.write;
      cnt <= cnt + 1;
      if (i_bus.write === 1'b1)
        mem[i_bus.addr[7:0]] <= i_bus.data;
    end
  end
endmodule
`default_nettype wire

//--- bench/accx_core_tb.sv
// accx_core_tb: self-checking bench for the accumulator, ccr and bank core.
// assumes the apb map and op codes of accx_pkg and a 10 MHz clock.
`default_nettype none
module accx_core_tb
  import accx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [15:0] d;
    logic [15:0] e;
    accx_op_t    c;
    logic [15:0] xd;
    logic [15:0] xe;
  } accx_row_t;
  localparam accx_row_t ROWS [7] = '{
    '{16'h12FF, 16'h0000, ACCX_OP_INCA, 16'h13FF, 16'h0000},
    '{16'h1200, 16'h0000, ACCX_OP_DECA, 16'h1100, 16'h0000},
    '{16'h12FF, 16'h0000, ACCX_OP_INCB, 16'h1200, 16'h0000},
    '{16'h1200, 16'h0000, ACCX_OP_DECB, 16'h12FF, 16'h0000},
    '{16'h0A00, 16'h0000, ACCX_OP_DAA,  16'h1000, 16'h0000},
    '{16'h0003, 16'h0005, ACCX_OP_ADE,  16'h0003, 16'h0008},
    '{16'h0003, 16'h0005, ACCX_OP_SDE,  16'h0003, 16'h0002}};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  irq_level = 3'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq_taken;
  accx_bus_t   bus;
  logic [19:0] m_addr;
  logic [31:0] m_data;
  logic        m_wr;
  int          m_cnt;
  int          fails = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          irq_cnt = 0;
  logic [31:0] q;
  logic        err;
  always #50 clk = ~clk;
  accx_core dut_u (.I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_IRQ_LEVEL(irq_level), .O_BUS(bus),
    .O_IRQ_TAKEN(irq_taken));
  accx_mem_model mem_u (.i_clk(clk), .i_bus(bus), .o_last_addr(m_addr),
    .o_last_data(m_data), .o_last_write(m_wr), .o_count(m_cnt));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (irq_taken === 1'b1)
      irq_cnt <= irq_cnt + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run = tests_run + 1;
    if (got !== exp)
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    if (got !== exp)
      fails = fails + 1;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20000) begin
      n++;
      @(posedge clk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // read word is latched at setup and taken at the access edge
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic op(input accx_op_t c, input accx_bk_t b);
    wr(ACCX_OFS_OP, {21'h0, b, 3'h0, c});
    repeat (3) @(posedge clk);
  endtask
  task automatic rd16(input logic [7:0] a, input logic [15:0] exp, input string msg);
    rd(a);
    chk({16'h0, q[15:0]}, {16'h0, exp}, msg);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd16(ACCX_OFS_CCR, ACCX_CCR_RESET, "ccr after reset");
    for (int i = 0; i < 7; i++) begin
      wr(ACCX_OFS_ACC_D, {16'h0, ROWS[i].d});
      wr(ACCX_OFS_ACC_E, {16'h0, ROWS[i].e});
      op(ROWS[i].c, ACCX_BK_X);
      rd16(ACCX_OFS_ACC_D, ROWS[i].xd, "acc d");
      rd16(ACCX_OFS_ACC_E, ROWS[i].xe, "acc e");
    end
    $display("test op table done");
    wr(ACCX_OFS_ACC_D, 32'h0000_7F00);
    op(ACCX_OP_INCA, ACCX_BK_X);
    rd(ACCX_OFS_CCR);
    chk({29'h0, q[ACCX_CCR_N:ACCX_CCR_V]}, 32'h5, "nzv after inc");
    wr(ACCX_OFS_ACC_D, 32'h0000_0100);
    op(ACCX_OP_DECA, ACCX_BK_X);
    rd(ACCX_OFS_CCR);
    chk({29'h0, q[ACCX_CCR_N:ACCX_CCR_V]}, 32'h2, "nzv after dec");
    $display("test flags done");
    wr(ACCX_OFS_ACC_D, 32'h0000_000B);
    op(ACCX_OP_BKLD, ACCX_BK_E);
    wr(ACCX_OFS_OPND, 32'h89AB_4567);
    op(ACCX_OP_LD32, ACCX_BK_X);
    rd16(ACCX_OFS_ACC_E, 16'h89AB, "pair high");
    rd16(ACCX_OFS_ACC_D, 16'h4567, "pair low");
    wr(ACCX_OFS_OPND, 32'h0000_2468);
    op(ACCX_OP_ST32, ACCX_BK_E);
    chk(m_cnt, 32'h1, "store pulses");
    chk(m_data, 32'h89AB_4567, "store data");
    chk({11'h0, m_wr, m_addr}, 32'h001B_2468, "store addr");
    wr(ACCX_OFS_ACC_D, 32'h0000_FFF0);
    op(ACCX_OP_BKRD, ACCX_BK_E);
    rd(ACCX_OFS_ACC_D);
    chk({20'h0, q[15:8], q[3:0]}, 32'hFFB, "bank to low acc");
    $display("test pair and banks done");
    wr(ACCX_OFS_ACC_D, 32'h0000_0005);
    op(ACCX_OP_BKLD, ACCX_BK_Y);
    wr(ACCX_OFS_PTRS, 32'h0001_FFF0);
    wr(ACCX_OFS_ACC_E, 32'h0000_0020);
    op(ACCX_OP_STE, ACCX_BK_Y);
    chk({11'h0, m_wr, m_addr}, 32'h0016_0010, "carry access");
    wr(ACCX_OFS_ACC_E, 32'h0000_0008);
    op(ACCX_OP_STE, ACCX_BK_Y);
    chk({12'h0, m_addr}, 32'h5_FFF8, "next access");
    op(ACCX_OP_LDE, ACCX_BK_Y);
    chk({11'h0, m_wr, m_addr}, 32'h0005_FFF8, "load access");
    rd16(ACCX_OFS_BANKS, 16'h050B, "bank register");
    $display("test segment carry done");
    wr(ACCX_OFS_OPND, 32'h0003_FFFE);
    op(ACCX_OP_CALL, ACCX_BK_X);
    op(ACCX_OP_PCINC, ACCX_BK_X);
    rd(ACCX_OFS_SKPC);
    chk({12'h0, q[19:0]}, 32'h4_0000, "pc carry");
    rd(ACCX_OFS_CCR);
    chk({28'h0, q[3:0]}, 32'h4, "pc bank");
    wr(ACCX_OFS_OPND, 32'h0000_1234);
    op(ACCX_OP_CALL, ACCX_BK_X);
    wr(ACCX_OFS_CCR, 32'h0000_0840);
    op(ACCX_OP_RET, ACCX_BK_X);
    rd(ACCX_OFS_SKPC);
    chk({12'h0, q[19:0]}, 32'h4_0000, "return pc");
    rd16(ACCX_OFS_CCR, 16'h0844, "return ccr");
    $display("test call return done");
    for (int i = 0; i < 4; i++) begin
      wr(ACCX_OFS_CCR, {24'h0, (i < 2) ? 3'h3 : 3'h7, 5'h00});
      @(posedge clk);
      irq_level <= 3'(i + ((i < 2) ? 3 : 4));
      repeat (4) @(posedge clk);
      rd(ACCX_OFS_IRQ);
      chk({31'h0, q[3]}, {31'h0, i[0]}, "irq accept");
    end
    irq_level <= 3'h3;
    repeat (4) @(posedge clk);
    op(ACCX_OP_IRQ, ACCX_BK_X);
    chk(irq_cnt, 32'h0, "masked irq");
    irq_level <= 3'h7;
    repeat (4) @(posedge clk);
    op(ACCX_OP_IRQ, ACCX_BK_X);
    chk(irq_cnt, 32'h1, "level 7 irq");
    rd(ACCX_OFS_STK1);
    chk(q, 32'h00E0_0000, "irq stack word");
    $display("test irq done");
    rd(8'h3C);
    chk({31'h0, err}, 32'h1, "unmapped error");
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd16(ACCX_OFS_CCR, ACCX_CCR_RESET, "ccr after reset");
    rd16(ACCX_OFS_ACC_E, 16'h0000, "acc e after reset");
    $display("test reset done");
    end_sim();
  end
endmodule
`default_nettype wire
